// file: src/calibration_command_interpreter.sv
`timescale 1ns/1ps
`default_nettype none
module calibration_command_interpreter
  import cal_cmd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,     // one-cycle word strobe
  input wire logic [15:0] cmd_word_i,
  input wire logic [13:0] bridge_raw_i,
  input wire logic [10:0] temp_raw_i,
  input wire logic [7:0] corr_byte_i, // corrected stream byte
  input wire logic sample_i,        // one-cycle: next output byte wanted
  output logic [1:0] mode_o,        // 0 normal 1 command 2 raw
  output logic [7:0] output_pin_o,  // byte toward output pin serialiser
  output logic out_valid_o,
  output logic [14:0] gain_b_o,
  output logic [13:0] offs_b_o,
  output logic [7:0] gain_t_o,
  output logic [7:0] offs_t_o,
  output logic [7:0] low_cal_temp_ref_o,
  output logic [7:0] second_order_term_o,
  output logic [7:0] tco_o,
  output logic [7:0] tcg_o,
  output logic [11:0] test_start_o
);
  ////////////////////////////////////////////////////////////////////
  // state and decoded word
  mode_type mode_q;
  logic [3:0] nib;
  logic [11:0] dat;
  logic prog; // programming allowed only in command mode
  logic [1:0] idx_q; // byte position in raw frame
  logic [13:0] br_q; // frame snapshot
  logic [10:0] tp_q;
  // the word splits into nibble and data; prog gates every write except those of the entry word
  assign nib = cmd_word_i[15:12];
  assign dat = cmd_word_i[11:0];
  assign prog = cmd_valid_i && (mode_q == command_interpret_mode);
  // mode code for the outside world; the enum itself stays private
  assign mode_o = (mode_q == normal_operating_mode) ? 2'h0 :
                  (mode_q == command_interpret_mode) ? 2'h1 : 2'h2;
  ////////////////////////////////////////////////////////////////////
  // mode machine; entry word always heard so a stuck part recovers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      mode_q <= normal_operating_mode;
    else if (cmd_valid_i && nib == CMD_ENTER)
      mode_q <= command_interpret_mode;
    else if (prog && nib == CMD_MODE)
    begin
      // unknown data leaves the mode unchanged
      case (dat)
        DATA_NORMAL: mode_q <= normal_operating_mode;
        DATA_RAW: mode_q <= uncorrected_output_mode;
        default: mode_q <= mode_q;
      endcase
    end
  end
  // test start latch
  // a zero data entry word keeps the old start value
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      test_start_o <= 12'h000;
    else if (cmd_valid_i && nib == CMD_ENTER && dat != DATA_NORMAL)
      test_start_o <= dat;
  end
  ////////////////////////////////////////////////////////////////////
  // coefficient fields, written from the low data byte
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      gain_b_o <= GAIN_B_RST;
      offs_b_o <= OFFS_B_RST;
      gain_t_o <= GAIN_T_RST;
      offs_t_o <= FIELD_RST;
      low_cal_temp_ref_o <= FIELD_RST;
      second_order_term_o <= FIELD_RST;
      tco_o <= FIELD_RST;
      tcg_o <= FIELD_RST;
    end
    else if (prog)
    begin
      // spare top bits are kept at zero by the master and dropped here
      case (nib)
        CMD_GB_HI: gain_b_o[14:8] <= dat[6:0];
        CMD_GB_LO: gain_b_o[7:0] <= dat[7:0];
        CMD_OB_HI: offs_b_o[13:8] <= dat[5:0];
        CMD_OB_LO: offs_b_o[7:0] <= dat[7:0];
        CMD_TSET: low_cal_temp_ref_o <= dat[7:0];
        CMD_SECOND_ORDER: second_order_term_o <= dat[7:0];
        CMD_GT: gain_t_o <= dat[7:0];
        CMD_OT: offs_t_o <= dat[7:0];
        CMD_TCO: tco_o <= dat[7:0];
        CMD_TCG: tcg_o <= dat[7:0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // output byte stream; raw frame snapshotted at its first byte
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      idx_q <= 2'h0;
      br_q <= 14'h0000;
      tp_q <= 11'h000;
      output_pin_o <= 8'h00;
      out_valid_o <= 1'b0;
    end
    else
    begin
      out_valid_o <= sample_i;
      if (sample_i && mode_q == uncorrected_output_mode)
      begin
        idx_q <= (idx_q == FRAME_LAST) ? 2'h0 : idx_q + 2'h1;
        // byte 0 freezes both conversions so a frame never mixes samples
        case (idx_q)
          2'h0:
          begin
            br_q <= bridge_raw_i;
            tp_q <= temp_raw_i;
            output_pin_o <= {2'b00, bridge_raw_i[13:8]};
          end
          2'h1: output_pin_o <= br_q[7:0];
          default: output_pin_o <= tp_q[7:0];
        endcase
      end
      // outside raw mode the corrected byte passes and the frame restarts
      else if (sample_i)
      begin
        idx_q <= 2'h0;
        output_pin_o <= corr_byte_i;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // mode changes: the word is taken at one edge, the mode shows at the next
  chk_raw_entry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && cmd_word_i == 16'h4010 |=> mode_o == 2'h2) else $error("raw entry");
  chk_normal_entry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && cmd_word_i == 16'h4000 |=> mode_o == 2'h0) else $error("normal entry");
  chk_cmd_entry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_valid_i && nib == CMD_ENTER |=> mode_o == 2'h1) else $error("cmd entry");
  // an unknown mode code leaves the machine where it was
  chk_mode_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_MODE && dat != DATA_NORMAL && dat != DATA_RAW |=> $stable(mode_o))
    else $error("mode kept");
  chk_test_latch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_valid_i && nib == CMD_ENTER && dat != 12'h000 |=> test_start_o == $past(dat))
    else $error("test start");
  chk_entry_keeps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_valid_i && nib == CMD_ENTER && dat == DATA_NORMAL |=> $stable(test_start_o))
    else $error("test start kept");
  ////////////////////////////////////////////////////////////////////
  // field writes land one edge after the word
  chk_gain_hi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_GB_HI |=> gain_b_o[14:8] == $past(dat[6:0])) else $error("gain hi");
  chk_gain_lo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_GB_LO |=> gain_b_o[7:0] == $past(dat[7:0])) else $error("gain lo");
  chk_offs_hi: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_OB_HI |=> offs_b_o[13:8] == $past(dat[5:0])) else $error("offs hi");
  chk_offs_lo: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_OB_LO |=> offs_b_o[7:0] == $past(dat[7:0])) else $error("offs lo");
  chk_tset_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_TSET |=> low_cal_temp_ref_o == $past(dat[7:0])) else $error("tset");
  chk_tco_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_TCO |=> tco_o == $past(dat[7:0])) else $error("tco");
  chk_tcg_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_TCG |=> tcg_o == $past(dat[7:0])) else $error("tcg");
  chk_gt_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_GT |=> gain_t_o == $past(dat[7:0])) else $error("gain t");
  chk_ot_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_OT |=> offs_t_o == $past(dat[7:0])) else $error("offs t");
  chk_second_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    prog && nib == CMD_SECOND_ORDER |=> second_order_term_o == $past(dat[7:0]))
    else $error("second order");
  // words outside command mode, other than the entry word, must not touch gain_b_o, tcg_o or the mode
  chk_unknown_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cmd_valid_i && !prog && nib != CMD_ENTER |=>
    $stable(gain_b_o) && $stable(tcg_o) && $stable(mode_o)) else $error("ignored word");
  // reset brings both gains back to unity
  chk_reset_unity: assert property (@(posedge sys_clk_i)
    rst_i |=> gain_b_o == GAIN_B_RST && gain_t_o == GAIN_T_RST) else $error("unity reset");
  ////////////////////////////////////////////////////////////////////
  // raw frame steps, one sample strobe each at its byte position
  sequence raw_first_seq;
    sample_i && mode_q == uncorrected_output_mode && idx_q == 2'h0;
  endsequence
  sequence raw_second_seq;
    sample_i && mode_q == uncorrected_output_mode && idx_q == 2'h1;
  endsequence
  sequence raw_third_seq;
    sample_i && mode_q == uncorrected_output_mode && idx_q == FRAME_LAST;
  endsequence
  // a frame read at the usual pace of one strobe every other cycle
  sequence raw_pair_seq;
    raw_first_seq ##2 raw_second_seq;
  endsequence
  chk_high_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_first_seq |=> output_pin_o == {2'b00, $past(bridge_raw_i[13:8])})
    else $error("high byte");
  // later bytes come from the snapshot, not from the live converter inputs
  chk_bridge_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_pair_seq |=> output_pin_o == $past(bridge_raw_i[7:0], 3)) else $error("bridge low");
  chk_temp_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_pair_seq ##2 raw_third_seq |=> output_pin_o == $past(temp_raw_i[7:0], 5))
    else $error("temp byte");
  chk_frame_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    raw_third_seq |=> idx_q == 2'h0) else $error("frame wrap");
  // outside raw mode the corrected byte passes straight through
  chk_corr_pass: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sample_i && mode_q != uncorrected_output_mode |=> output_pin_o == $past(corr_byte_i))
    else $error("corrected byte");
  // every strobe gives exactly one valid pulse
  chk_valid_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    sample_i |=> out_valid_o) else $error("valid pulse");
  chk_valid_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !sample_i |=> !out_valid_o) else $error("valid quiet");
endmodule
`default_nettype wire

// file: src/cal_cmd_pkg.sv
`default_nettype none
package cal_cmd_pkg;
  // command nibbles
  localparam logic [3:0] CMD_MODE = 4'h4;
  localparam logic [3:0] CMD_ENTER = 4'h5;
  localparam logic [3:0] CMD_SECOND_ORDER = 4'h6;
  localparam logic [3:0] CMD_TSET = 4'h7;
  localparam logic [3:0] CMD_GB_HI = 4'h8;
  localparam logic [3:0] CMD_GB_LO = 4'h9;
  localparam logic [3:0] CMD_OB_HI = 4'hA;
  localparam logic [3:0] CMD_OB_LO = 4'hB;
  localparam logic [3:0] CMD_GT = 4'hC;
  localparam logic [3:0] CMD_OT = 4'hD;
  localparam logic [3:0] CMD_TCO = 4'hE;
  localparam logic [3:0] CMD_TCG = 4'hF;
  // data codes
  localparam logic [11:0] DATA_NORMAL = 12'h000;
  localparam logic [11:0] DATA_RAW = 12'h010;
  // reset values
  localparam logic [14:0] GAIN_B_RST = 15'h0800;
  localparam logic [7:0] GAIN_T_RST = 8'h80;
  localparam logic [13:0] OFFS_B_RST = 14'h0000;
  localparam logic [7:0] FIELD_RST = 8'h00;
  // index of the last byte in a three-byte frame
  localparam logic [1:0] FRAME_LAST = 2'h2;
  typedef enum {normal_operating_mode, command_interpret_mode,
                uncorrected_output_mode} mode_type;
endpackage
`default_nettype wire

// file: tb/cal_master_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// calibration master: one word per strobe, spaced a cycle apart
module cal_master_model
(
  input wire logic sys_clk_i,
  output logic cmd_valid_o,
  output logic [15:0] cmd_word_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_word_o = 16'h0000;
  end
  // word inverted after release, so a stale word never looks valid
  task automatic send(input logic [15:0] w);
  begin
    if (w[15:12] == 4'h8) w[7] = 1'b0;
    if (w[15:12] == 4'hA) w[7:6] = 2'b00;
    @(posedge sys_clk_i) #1 cmd_valid_o = 1'b1;
    cmd_word_o = w;
    @(posedge sys_clk_i) #1 cmd_valid_o = 1'b0;
    cmd_word_o = ~w;
  end
  endtask
  // unity gains, then command mode, then raw mode
  task automatic raw_entry();
  begin
    send(16'h8008);
    send(16'h9000);
    send(16'hC080);
    send(16'h5000);
    send(16'h4010);
  end
  endtask
endmodule
`default_nettype wire

// file: tb/calibration_command_interpreter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module calibration_command_interpreter_tb_top;
  logic clk, rst, smp, cv, ov;
  logic [15:0] cw, e, g;
  logic [14:0] gb = 15'h0800, gbo;
  logic [13:0] ob = 14'h0000, br, b, obo;
  logic [10:0] tr, t;
  logic [7:0] cb, d, pin, gt, ot, tl, so, tco, tcg, hi;
  logic [11:0] ts;
  logic [3:0] n;
  logic [1:0] md;
  int fails = 0, n_checks = 0, seed = 32'h4c22;
  int sb, eb; // seen and expected bridge sums over one point
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  cal_master_model cal_master_model_i (.sys_clk_i(clk), .cmd_valid_o(cv), .cmd_word_o(cw));
  calibration_command_interpreter calibration_command_interpreter_i (.sys_clk_i(clk),
    .rst_i(rst), .cmd_valid_i(cv), .cmd_word_i(cw), .bridge_raw_i(br), .temp_raw_i(tr),
    .corr_byte_i(cb), .sample_i(smp), .mode_o(md), .output_pin_o(pin), .out_valid_o(ov),
    .gain_b_o(gbo), .offs_b_o(obo), .gain_t_o(gt), .offs_t_o(ot), .low_cal_temp_ref_o(tl),
    .second_order_term_o(so), .tco_o(tco), .tcg_o(tcg), .test_start_o(ts));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] x, input logic [15:0] y);
  begin
    n_checks++;
    if (y !== x)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  end
  endtask
  // one sample pulse; the byte shows one cycle later
  task automatic take(input logic [7:0] x);
  begin
    @(posedge clk) #1 smp = 1'b1;
    @(posedge clk) #1 smp = 1'b0;
    chk("out_valid", 16'h0001, 16'(ov));
    chk("output_pin", 16'(x), 16'(pin));
  end
  endtask
  // expected raw frame byte from the conversions present at byte 0
  function automatic logic [7:0] raw_byte(input int k, input logic [13:0] rb,
    input logic [10:0] rt);
  begin
    if (k == 0)
      raw_byte = {2'b00, rb[13:8]};
    else if (k == 1)
      raw_byte = rb[7:0];
    else
      raw_byte = rt[7:0];
  end
  endfunction
  task automatic conclude();
  begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // watchdog: tests need a few hundred cycles
  initial
  begin
    repeat (2000) @(posedge clk);
    fails++;
    conclude();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    smp = 1'b0;
    br = 14'h0000;
    tr = 11'h000;
    cb = 8'h00;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    chk("gain_t", 16'h0080, 16'(gt));
    cal_master_model_i.send(16'h8012);
    chk("gain_b", 16'h0800, 16'(gbo));
    cal_master_model_i.send(16'h5000);
    chk("mode", 16'h0001, 16'(md));
    // every program command, random data, upper bits masked by master
    for (int i = 6; i < 16; i++)
    begin
      n = i[3:0];
      d = 8'($random(seed));
      cal_master_model_i.send({n, 4'h0, d});
      if (n == 4'h8) gb[14:8] = d[6:0];
      if (n == 4'h9) gb[7:0] = d;
      if (n == 4'hA) ob[13:8] = d[5:0];
      if (n == 4'hB) ob[7:0] = d;
      e = (n == 4'h8 || n == 4'h9) ? 16'(gb) : (n == 4'hA || n == 4'hB) ? 16'(ob) : 16'(d);
      case (n)
        4'h6: g = 16'(so);
        4'h7: g = 16'(tl);
        4'h8, 4'h9: g = 16'(gbo);
        4'hA, 4'hB: g = 16'(obo);
        4'hC: g = 16'(gt);
        4'hD: g = 16'(ot);
        4'hE: g = 16'(tco);
        default: g = 16'(tcg);
      endcase
      chk("field", e, g);
    end
    cal_master_model_i.send(16'h1234);
    cal_master_model_i.send(16'h4123);
    chk("mode", 16'h0001, 16'(md));
    cal_master_model_i.send(16'h5123);
    chk("test_start", 16'h0123, 16'(ts));
    $display("test fields done");
    cal_master_model_i.raw_entry();
    chk("mode", 16'h0002, 16'(md));
    // zero entry data leaves the latched start value alone
    chk("test_start", 16'h0123, 16'(ts));
    // two points of sixteen frames; inputs change after byte 0
    for (int p = 0; p < 2; p++)
    begin
      sb = 0;
      eb = 0;
      repeat (16)
      begin
        br = 14'($random(seed));
        tr = 11'($random(seed));
        b = br;
        t = tr;
        take(raw_byte(0, b, t));
        hi = pin;
        br = ~br;
        tr = ~tr;
        take(raw_byte(1, b, t));
        sb += int'({hi[5:0], pin});
        eb += int'(b);
        take(raw_byte(2, b, t));
      end
      chk("bridge_average", 16'(eb / 16), 16'(sb / 16));
    end
    // raw mode only hears the entry word, so return through command mode
    cal_master_model_i.send(16'h5000);
    cal_master_model_i.send(16'h4000);
    chk("mode", 16'h0000, 16'(md));
    cb = 8'($random(seed));
    take(cb);
    $display("test raw done");
    conclude();
  end
endmodule
`default_nettype wire
